/* tb/qudit_readout_result_logger_tb_top.sv */
// self-checking bench: bus tasks, reference model and far-end controller
`timescale 1ns/1ns
`include "qrl_map.svh"
module qudit_readout_result_logger_tb_top import qrl_pkg::*; ;
  localparam logic [31:0] all_ones = 32'hFFFF_FFFF;
  logic          clk, rst_n, hsel, hwrite, ext_opt, trig, rvalid, dio_rdy, hrdy, strobe, hresp;
  logic [1:0]    htrans;
  logic [31:0]   haddr, hwdata, hrdata, ires, dbits, ctrl, x;
  logic [31:0]   mem[NPT];
  logic [LB-1:0] ldata, lvalid, fwd;
  logic [7:0]    words;
  integer        seed;
  int            failures, checks_done, acq, herr, hjob, ovf, len, avg, nwords, r;
  int            nst[NQ], qen[NQ], src[LB];
  int            cd[7] = '{4, 3, 4, 4, 4, 3, 2};

  qudit_readout_result_logger dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .ext_opt_in(ext_opt), .trigger_in(trig),
    .result_valid_in(rvalid), .int_result_in(ires), .disc_bits_in(dbits),
    .dio_ready_in(dio_rdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .link_data_out(ldata), .link_valid_out(lvalid), .link_strobe_out(strobe));
  sync_link_controller far_u (.clk_in(clk), .rst_n_in(rst_n), .data_in(ldata),
    .valid_in(lvalid), .strobe_in(strobe), .fwd_out(fwd), .words_out(words));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test;
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for the bus ready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      n++;
      if (n > 50) begin
        failures++;
        finish_test();
      end
      @(posedge clk);
    end
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    // read data is taken at the edge that closes the data phase
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q & m, e & m);
    chk(32'(hresp), 32'h0);
  endtask : rd

  // integrators go in index order to enabled qudits that still fit
  task automatic check_alloc;
    int used, need;
    logic ok;
    logic [31:0] w, m;
    used = 0;
    ok = 1'b1;
    for (int q = 0; q < NQ; q++) begin
      need = nst[q] - 1;
      w = {13'h0, 3'(nst[q] * need / 2), 2'h0, 2'(need), 4'(used), 3'h0,
           1'(need + used <= NINT), 1'(qen[q]), 3'(nst[q])};
      m = 32'h0007_001F;
      if (qen[q] != 0 && need + used <= NINT) begin
        m = 32'h0007_3F1F;
        used += need;
      end else if (qen[q] != 0)
        ok = 1'b0;
      rd(32'h40 + 4 * q, w, m);
    end
    w = {15'h0, ok, 8'(used * 100 / NINT), 2'h0, 6'(used)};
    rd(`QRL_MSSTAT_OFS, w, all_ones);
  endtask : check_alloc

  function automatic logic [1:0] lexp(input int c);
    if (c < 16 || (c < 32 && ext_opt))
      return {1'b1, dbits[c]};
    return {1'b0, c == 'h21};
  endfunction : lexp

  // one trigger and its result; ho adds a trigger while the result is pending
  task automatic acquire(input logic ho, input logic res);
    int a, p, k;
    logic [31:0] v;
    logic [1:0] e;
    logic [LB-1:0] ed, ev, mk;
    a = acq;
    trig <= 1'b1;
    @(posedge clk);
    trig <= ho;
    @(posedge clk);
    trig <= 1'b0;
    if (ctrl[`QRL_LOGEN_BIT] && a < len * avg) begin
      acq++;
      if (ho) begin
        herr++;
        hjob = acq;
      end
    end else
      res = 1'b0;
    if (res) begin
      ires    <= $random(seed);
      // qudit 6 bits are driven although it holds no integrators
      dbits   <= $random(seed) & 32'h0000_3FFF;
      dio_rdy <= 1'($random(seed));
      ext_opt <= 1'($random(seed));
      rvalid  <= 1'b1;
      @(posedge clk);
      rvalid <= 1'b0;
      repeat (3) @(posedge clk);
      ovf += !dio_rdy;
      p = ctrl[`QRL_MODE_BIT] ? a / avg : a % len;
      k = ctrl[`QRL_MODE_BIT] ? a % avg : a / len;
      v = ctrl[`QRL_SRC_LSB +: 2] == `QRL_SRC_DISC ?
          dbits & {32{ctrl[`QRL_MSEN_BIT]}} & 32'h0000_0FFF : ires;
      if (k == 0)
        mem[p] = v;
      else if (ctrl[`QRL_SRC_LSB +: 2] == `QRL_SRC_DISC)
        mem[p] = mem[p] + v;
      else
        mem[p] = {mem[p][31:16] + v[31:16], mem[p][15:0] + v[15:0]};
      nwords += ctrl[`QRL_MSEN_BIT];
      for (int b = 0; b < LB; b++) begin
        e = lexp(ctrl[`QRL_PACK_BIT] ? b : src[b]);
        ev[b] = e[1];
        ed[b] = e[0];
      end
      // packed tail beyond the six allocated qudits is left unchecked
      mk = ctrl[`QRL_PACK_BIT] ? 16'h0FFF : 16'hFFFF;
      if (ctrl[`QRL_MSEN_BIT]) begin
        chk(32'(lvalid & mk), 32'(ev & mk));
        chk(32'(ldata & mk), 32'(ed & mk));
        chk(32'(fwd & mk), 32'(ed & ev & mk));
      end
      chk(32'(words), 32'(nwords));
    end else
      repeat (2) @(posedge clk);
  endtask : acquire

  task automatic run(input logic [31:0] c, input int l, input int v, input int n);
    wr(`QRL_CTRL_OFS, 32'h0);
    ctrl = c;
    len = l;
    avg = v;
    acq = 0;
    wr(`QRL_LEN_OFS, l);
    wr(`QRL_AVG_OFS, v);
    wr(`QRL_CTRL_OFS, c);
    for (int i = 0; i < n; i++) acquire(i == 1, 1'b1);
    for (int p = 0; p < len; p++) rd(32'h80 + 4 * p, mem[p], all_ones);
    rd(`QRL_ACQ_OFS, acq, all_ones);
    rd(`QRL_ERRCNT_OFS, herr, all_ones);
    rd(`QRL_ERRJOB_OFS, hjob, all_ones);
    rd(`QRL_OVERDIO_OFS, ovf, all_ones);
  endtask : run

  initial begin
    seed = 93;
    {hsel, hwrite, ext_opt, trig, rvalid, rst_n} = '0;
    dio_rdy = 1'b1;
    htrans = 2'h0;
    {haddr, hwdata, ires, dbits, ctrl} = '0;
    {failures, checks_done, acq, herr, hjob, ovf, nwords} = '0;
    len = 1;
    avg = 1;
    foreach (nst[q]) nst[q] = 2;
    foreach (qen[q]) qen[q] = 0;
    foreach (src[b]) src[b] = 'h20;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`QRL_CTRL_OFS, 32'h0, all_ones);
    rd(`QRL_LEN_OFS, 32'(`QRL_LEN_RST), all_ones);
    rd(`QRL_AVG_OFS, 32'(`QRL_AVG_RST), all_ones);
    rd(32'h24, 32'h0, all_ones);
    rd(32'h30, 32'h2020_2020, 32'h3F3F_3F3F);
    check_alloc();
    acquire(1'b0, 1'b0);
    rd(`QRL_ACQ_OFS, 32'h0, all_ones);
    for (int i = 0; i < 7; i++) begin
      nst[i] = cd[i];
      qen[i] = 1;
      wr(32'h40 + 4 * i, {28'h0, 1'b1, 3'(cd[i])});
      if (i == 2) check_alloc();
    end
    wr(32'h5C, 32'h5);
    wr(32'h5C, 32'h1);
    check_alloc();
    for (int b = 0; b < LB; b++) begin
      r = $random(seed) & 15;
      src[b] = r < 12 ? r : r == 12 ? 16 : r == 13 ? 'h20 : 'h21;
    end
    src[15] = 16;
    for (int w = 0; w < 4; w++) begin
      x = {2'h0, 6'(src[4*w+3]), 2'h0, 6'(src[4*w+2]), 2'h0, 6'(src[4*w+1]), 2'h0, 6'(src[4*w])};
      wr(32'h30 + 4 * w, x);
      rd(32'h30 + 4 * w, x, 32'h3F3F_3F3F);
    end
    run(32'h0000_0005, 3, 2, 7);
    wr(`QRL_ERRCLR_OFS, 32'h1);
    herr = 0;
    rd(`QRL_ERRCNT_OFS, 32'h0, all_ones);
    run(32'h0000_0317, 2, 3, 7);
    wr(32'h30, 32'h2121_2121);
    rd(32'h30, 32'h0302_0100, 32'h3F3F_3F3F);
    wr(`QRL_CTRL_OFS, 32'h0000_0001);
    rd(32'h30, {2'h0, 6'(src[3]), 2'h0, 6'(src[2]), 2'h0, 6'(src[1]), 2'h0, 6'(src[0])},
       32'h3F3F_3F3F);
    run(32'h0000_0304, 1, 1, 2);
    finish_test();
  end
endmodule : qudit_readout_result_logger_tb_top

/* tb/sync_link_controller.sv */
// far-end feedback controller model: takes link words and forwards only the valid bits
`timescale 1ns/1ns
module sync_link_controller import qrl_pkg::*; (
  input  wire logic          clk_in,    // system clock
  input  wire logic          rst_n_in,  // async reset, active low
  input  wire logic [LB-1:0] data_in,   // link bits
  input  wire logic [LB-1:0] valid_in,  // link bit valid flags
  input  wire logic          strobe_in, // one pulse per link word
  output logic      [LB-1:0] fwd_out,   // last forwarded word
  output logic      [7:0]    words_out  // link words taken
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fwd_out   <= '0;
      words_out <= 8'h00;
    end else if (strobe_in) begin
      // fixed sources arrive flagged invalid and must never reach feedback
      fwd_out   <= data_in & valid_in;
      words_out <= words_out + 8'h01;
    end
  end
endmodule : sync_link_controller

/* verilog/qrl_map.svh */
// register offsets, field positions, reset values and codes of the readout logger
`ifndef QRL_MAP_SVH
`define QRL_MAP_SVH
`define QRL_CTRL_OFS    8'h00
`define QRL_LEN_OFS     8'h04
`define QRL_AVG_OFS     8'h08
`define QRL_ERRCLR_OFS  8'h0C
`define QRL_ERRCNT_OFS  8'h10
`define QRL_ERRJOB_OFS  8'h14
`define QRL_OVERDIO_OFS 8'h18
`define QRL_ACQ_OFS     8'h1C
`define QRL_MSSTAT_OFS  8'h20
`define QRL_SRC_HI      4'h3
`define QRL_QUDIT_HI    2'h1
`define QRL_DATA_HI     2'h2
`define QRL_MSEN_BIT    0
`define QRL_PACK_BIT    1
`define QRL_LOGEN_BIT   2
`define QRL_MODE_BIT    4
`define QRL_SRC_LSB     8
`define QRL_QEN_BIT     3
`define QRL_AVAIL_BIT   4
`define QRL_START_LSB   8
`define QRL_NEED_LSB    12
`define QRL_THR_LSB     16
`define QRL_USAGE_LSB   8
`define QRL_VALID_BIT   16
`define QRL_NUMST_MIN   3'h2
`define QRL_NUMST_MAX   3'h4
`define QRL_LEN_RST     5'h01
`define QRL_AVG_RST     16'h0001
`define QRL_SRC_DISC    2'h3
`define QRL_SRC_FIXED0  6'h20
`define QRL_SRC_FIXED1  6'h21
`define QRL_EXT_QUDIT   4'h8
`define QRL_PERCENT     12'h064
`endif

/* verilog/qrl_pkg.sv */
// types and sizes shared by the readout logger
package qrl_pkg;
  localparam int NQ   = 16;
  localparam int NINT = 16;
  localparam int LB   = 16;
  localparam int NPT  = 16;
  typedef enum logic [0:0] {LOG_IDLE = 1'b0, LOG_WAIT = 1'b1} log_state_type;
  typedef logic [5:0] src_sel_type;
  typedef logic [2:0] numst_type;
endpackage : qrl_pkg

/* verilog/qudit_readout_result_logger.sv */
// qudit integrator allocation, sync-link bit mapping and averaging result logger
`timescale 1ns/1ns
`include "qrl_map.svh"

module qudit_readout_result_logger import qrl_pkg::*; (
  input  wire logic        ref_clk_in,       // 20 MHz clock
  input  wire logic        rst_n_in,         // async reset, active low
  input  wire logic        hsel_in,          // ahb slave select
  input  wire logic [31:0] haddr_in,         // ahb address
  input  wire logic [1:0]  htrans_in,        // ahb transfer type
  input  wire logic        hwrite_in,        // ahb write
  input  wire logic [2:0]  hsize_in,         // ahb size, word only
  input  wire logic [31:0] hwdata_in,        // ahb write data
  input  wire logic        hready_in,        // ahb bus ready
  input  wire logic        ext_opt_in,       // extended qudit option fitted
  input  wire logic        trigger_in,       // readout trigger pulse
  input  wire logic        result_valid_in,  // readout result pulse
  input  wire logic [31:0] int_result_in,    // complex result, re high, im low
  input  wire logic [31:0] disc_bits_in,     // two state bits per qudit
  input  wire logic        dio_ready_in,     // dio port can take a result
  output logic [31:0]      hrdata_out,       // ahb read data
  output logic             hreadyout_out,    // ahb ready out
  output logic             hresp_out,        // ahb response, always okay
  output logic [LB-1:0]    link_data_out,    // sync link bits
  output logic [LB-1:0]    link_valid_out,   // sync link bit valid
  output logic             link_strobe_out   // sync link word pulse
);
  logic        ms_en_reg, ms_en_next, pack_reg, pack_next, log_en_reg, log_en_next;
  logic        mode_reg, mode_next, wr_pend_reg, wr_pend_next;
  logic [1:0]  source_reg, source_next;
  logic [4:0]  len_reg, len_next;
  logic [15:0] avg_reg, avg_next, qen_reg, qen_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  numst_type   qd_reg [NQ];
  numst_type   qd_next [NQ];
  src_sel_type bsrc_reg [LB];
  src_sel_type bsrc_next [LB];
  logic        err_clr, restart, rd_take, wr_take;

  // integrator allocation, qudits served in index order
  logic [1:0]  need [NQ];
  logic [5:0]  start [NQ];
  logic [NQ-1:0] avail, alloc;
  logic [5:0]  used, total_req;
  logic [11:0] usage;
  logic        ms_valid;

  always_comb begin
    logic [5:0] run;
    run = 6'h00;
    total_req = 6'h00;
    for (int q = 0; q < NQ; q++) begin
      need[q] = 2'(qd_reg[q] - 3'h1);
      start[q] = run;
      avail[q] = (run + 6'(need[q])) <= 6'(NINT);
      alloc[q] = qen_reg[q] && avail[q];
      if (alloc[q]) run = run + 6'(need[q]);
      if (qen_reg[q]) total_req = total_req + 6'(need[q]);
    end
    used = run;
    usage = 12'((12'(used) * `QRL_PERCENT) / 12'(NINT));
    ms_valid = total_req <= 6'(NINT);
  end

  // qudit state bits, gated by multi-state mode and allocation
  logic [2*NQ-1:0] qbits;
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      qbits[2*q]   = ms_en_reg && alloc[q] && disc_bits_in[2*q];
      // a two-state qudit has one threshold, so its upper bit stays low
      qbits[2*q+1] = ms_en_reg && alloc[q] && qd_reg[q] != 3'h2
                     && disc_bits_in[2*q+1];
    end
  end

  // effective per-bit source: packed map or software choice
  src_sel_type esrc [LB];
  always_comb begin
    logic [5:0] pos;
    pos = 6'h00;
    for (int b = 0; b < LB; b++) esrc[b] = pack_reg ? `QRL_SRC_FIXED0 : bsrc_reg[b];
    if (pack_reg) begin
      for (int q = 0; q < NQ; q++) begin
        if (alloc[q]) begin
          if (pos < 6'(LB)) esrc[pos[3:0]] = 6'(2 * q);
          pos = pos + 6'h01;
          if (qd_reg[q] != 3'h2) begin
            if (pos < 6'(LB)) esrc[pos[3:0]] = 6'(2 * q + 1);
            pos = pos + 6'h01;
          end
        end
      end
    end
  end

  logic [LB-1:0] ldata, lvalid;
  always_comb begin
    for (int b = 0; b < LB; b++) begin
      lvalid[b] = !esrc[b][5] && (ext_opt_in || esrc[b][4:1] < `QRL_EXT_QUDIT);
      ldata[b]  = esrc[b] == `QRL_SRC_FIXED1 || (lvalid[b] && qbits[esrc[b][4:0]]);
      if (esrc[b][5]) lvalid[b] = 1'b0;
    end
  end

  // result logger state
  log_state_type st_reg, st_next;
  logic [20:0] acq_reg, acq_next, total;
  logic [4:0]  pt_reg, pt_next, wpt_reg, wpt_next;
  logic [15:0] rep_reg, rep_next;
  logic        first_reg, first_next;
  logic [31:0] errcnt_reg, errcnt_next, ovf_reg, ovf_next;
  logic [20:0] errjob_reg, errjob_next;
  logic [31:0] mem_reg [NPT];
  logic [31:0] mem_next [NPT];
  logic [LB-1:0] ldata_reg, ldata_next, lvalid_reg, lvalid_next;
  logic        lstb_reg, lstb_next;
  logic        accept, done, holdoff;

  assign total   = 21'(len_reg) * 21'(avg_reg);
  assign done    = acq_reg >= total;
  assign accept  = st_reg == LOG_IDLE && trigger_in && log_en_reg && !done;
  assign holdoff = st_reg == LOG_WAIT && trigger_in;

  // bus and configuration group
  assign rd_take = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  assign wr_take = hsel_in && htrans_in[1] && hready_in && hwrite_in;

  always_comb begin
    logic [7:0] a;
    logic [3:0] qi;
    a = haddr_in[7:0];
    qi = a[5:2];
    ms_en_next = ms_en_reg;
    pack_next = pack_reg;
    log_en_next = log_en_reg;
    mode_next = mode_reg;
    source_next = source_reg;
    len_next = len_reg;
    avg_next = avg_reg;
    qen_next = qen_reg;
    qd_next = qd_reg;
    bsrc_next = bsrc_reg;
    err_clr = 1'b0;
    restart = 1'b0;
    wr_pend_next = wr_take && haddr_in[31:8] == 24'h0;
    wr_addr_next = haddr_in[7:0];
    hrdata_next = 32'h0000_0000;
    if (wr_pend_reg && wr_addr_reg[7:4] == `QRL_SRC_HI) begin
      for (int k = 0; k < 4; k++) begin
        if (!pack_reg) bsrc_next[{wr_addr_reg[3:2], 2'(k)}] = hwdata_in[8*k +: 6];
      end
    end else if (wr_pend_reg && wr_addr_reg[7:6] == `QRL_QUDIT_HI) begin
      qen_next[wr_addr_reg[5:2]] = hwdata_in[`QRL_QEN_BIT];
      if (hwdata_in[2:0] >= `QRL_NUMST_MIN && hwdata_in[2:0] <= `QRL_NUMST_MAX) begin
        qd_next[wr_addr_reg[5:2]] = hwdata_in[2:0];
      end
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `QRL_CTRL_OFS: begin
          ms_en_next = hwdata_in[`QRL_MSEN_BIT];
          pack_next = hwdata_in[`QRL_PACK_BIT];
          log_en_next = hwdata_in[`QRL_LOGEN_BIT];
          mode_next = hwdata_in[`QRL_MODE_BIT];
          source_next = hwdata_in[`QRL_SRC_LSB +: 2];
          restart = hwdata_in[`QRL_LOGEN_BIT] && !log_en_reg;
        end
        `QRL_LEN_OFS: len_next = (hwdata_in[4:0] > 5'(NPT)) ? 5'(NPT) : hwdata_in[4:0];
        `QRL_AVG_OFS: avg_next = hwdata_in[15:0];
        `QRL_ERRCLR_OFS: err_clr = 1'b1;
        default: ;
      endcase
    end
    if (rd_take) begin
      if (a[7:4] == `QRL_SRC_HI) begin
        for (int k = 0; k < 4; k++) hrdata_next[8*k +: 6] = esrc[{a[3:2], 2'(k)}];
      end else if (a[7:6] == `QRL_QUDIT_HI) begin
        hrdata_next[2:0] = qd_reg[qi];
        hrdata_next[`QRL_QEN_BIT] = qen_reg[qi];
        hrdata_next[`QRL_AVAIL_BIT] = avail[qi];
        hrdata_next[`QRL_START_LSB +: 4] = start[qi][3:0];
        hrdata_next[`QRL_NEED_LSB +: 2] = alloc[qi] ? need[qi] : 2'h0;
        // product is widened first: four states give twelve before halving
        hrdata_next[`QRL_THR_LSB +: 3] =
          3'((6'(qd_reg[qi]) * (6'(qd_reg[qi]) - 6'h1)) >> 1);
      end else if (a[7:6] == `QRL_DATA_HI) begin
        hrdata_next = mem_reg[qi];
      end else begin
        unique case (a)
          `QRL_CTRL_OFS: hrdata_next = {22'h0, source_reg, 3'h0, mode_reg, 1'b0,
                                        log_en_reg, pack_reg, ms_en_reg};
          `QRL_LEN_OFS: hrdata_next = {27'h0, len_reg};
          `QRL_AVG_OFS: hrdata_next = {16'h0, avg_reg};
          `QRL_ERRCNT_OFS: hrdata_next = errcnt_reg;
          `QRL_ERRJOB_OFS: hrdata_next = {11'h0, errjob_reg};
          `QRL_OVERDIO_OFS: hrdata_next = ovf_reg;
          `QRL_ACQ_OFS: hrdata_next = {11'h0, acq_reg};
          `QRL_MSSTAT_OFS: hrdata_next = {15'h0, ms_valid, usage[7:0],
                                          2'h0, used};
          default: hrdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (haddr_in[31:8] != 24'h0) hrdata_next = 32'h0000_0000;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms_en_reg <= 1'b0;
      pack_reg <= 1'b0;
      log_en_reg <= 1'b0;
      mode_reg <= 1'b0;
      source_reg <= 2'h0;
      len_reg <= `QRL_LEN_RST;
      avg_reg <= `QRL_AVG_RST;
      qen_reg <= 16'h0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      for (int q = 0; q < NQ; q++) qd_reg[q] <= `QRL_NUMST_MIN;
      for (int b = 0; b < LB; b++) bsrc_reg[b] <= `QRL_SRC_FIXED0;
    end else begin
      ms_en_reg <= ms_en_next;
      pack_reg <= pack_next;
      log_en_reg <= log_en_next;
      mode_reg <= mode_next;
      source_reg <= source_next;
      len_reg <= len_next;
      avg_reg <= avg_next;
      qen_reg <= qen_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      qd_reg <= qd_next;
      bsrc_reg <= bsrc_next;
    end
  end

  // logger group
  always_comb begin
    logic [31:0] smp;
    smp = (source_reg == `QRL_SRC_DISC) ? qbits : int_result_in;
    st_next = st_reg;
    acq_next = acq_reg;
    pt_next = pt_reg;
    rep_next = rep_reg;
    wpt_next = wpt_reg;
    first_next = first_reg;
    mem_next = mem_reg;
    errcnt_next = err_clr ? 32'h0 : errcnt_reg;
    errjob_next = errjob_reg;
    ovf_next = ovf_reg;
    ldata_next = ldata_reg;
    lvalid_next = lvalid_reg;
    lstb_next = 1'b0;
    if (holdoff) begin
      errcnt_next = err_clr ? 32'h1 : errcnt_reg + 32'h1;
      errjob_next = acq_reg;
    end
    unique case (st_reg)
      LOG_IDLE: begin
        if (accept) begin
          acq_next = acq_reg + 21'h1;
          wpt_next = pt_reg;
          first_next = rep_reg == 16'h0;
          st_next = LOG_WAIT;
          if (mode_reg) begin
            rep_next = rep_reg + 16'h1;
            if (rep_reg + 16'h1 >= avg_reg) begin
              rep_next = 16'h0;
              pt_next = pt_reg + 5'h1;
            end
          end else begin
            pt_next = pt_reg + 5'h1;
            if (pt_reg + 5'h1 >= len_reg) begin
              pt_next = 5'h0;
              rep_next = rep_reg + 16'h1;
            end
          end
        end
      end
      LOG_WAIT: begin
        if (result_valid_in) begin
          st_next = LOG_IDLE;
          if (source_reg == `QRL_SRC_DISC) begin
            mem_next[wpt_reg[3:0]] = first_reg ? smp : mem_reg[wpt_reg[3:0]] + smp;
          end else begin
            // real and imaginary halves sum apart, each wraps in 16 bits
            mem_next[wpt_reg[3:0]][31:16] = (first_reg ? 16'h0 : mem_reg[wpt_reg[3:0]][31:16])
                                            + smp[31:16];
            mem_next[wpt_reg[3:0]][15:0] = (first_reg ? 16'h0 : mem_reg[wpt_reg[3:0]][15:0])
                                           + smp[15:0];
          end
          ldata_next = ldata;
          lvalid_next = lvalid;
          lstb_next = ms_en_reg;
          if (!dio_ready_in) ovf_next = ovf_reg + 32'h1;
        end
      end
    endcase
    if (restart) begin
      acq_next = 21'h0;
      pt_next = 5'h0;
      rep_next = 16'h0;
      st_next = LOG_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= LOG_IDLE;
      acq_reg <= 21'h0;
      pt_reg <= 5'h0;
      wpt_reg <= 5'h0;
      rep_reg <= 16'h0;
      first_reg <= 1'b1;
      errcnt_reg <= 32'h0;
      errjob_reg <= 21'h0;
      ovf_reg <= 32'h0;
      ldata_reg <= '0;
      lvalid_reg <= '0;
      lstb_reg <= 1'b0;
      for (int i = 0; i < NPT; i++) mem_reg[i] <= 32'h0;
    end else begin
      st_reg <= st_next;
      acq_reg <= acq_next;
      pt_reg <= pt_next;
      wpt_reg <= wpt_next;
      rep_reg <= rep_next;
      first_reg <= first_next;
      errcnt_reg <= errcnt_next;
      errjob_reg <= errjob_next;
      ovf_reg <= ovf_next;
      ldata_reg <= ldata_next;
      lvalid_reg <= lvalid_next;
      lstb_reg <= lstb_next;
      mem_reg <= mem_next;
    end
  end

  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign link_data_out = ldata_reg;
  assign link_valid_out = lvalid_reg;
  assign link_strobe_out = lstb_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence trig_taken; accept && !restart; endsequence
  sequence res_seen; st_reg == LOG_WAIT && result_valid_in; endsequence

  AST_NUMST_RANGE: assert property (qd_reg[0] >= 3'h2 && qd_reg[0] <= 3'h4)
    else $error("qudit state count left 2..4");
  AST_VALID_FLAG: assert property (qen_reg == alloc |-> ms_valid)
    else $error("valid low though all enabled qudits allocated");
  AST_ACQ_ADV: assert property (trig_taken |=> acq_reg == $past(acq_reg) + 21'h1)
    else $error("acquisition index did not advance");
  AST_STOP: assert property (done && !restart |=> acq_reg == $past(acq_reg))
    else $error("acquisition ran past length times averages");
  AST_ERR_CLR: assert property (err_clr && !holdoff |=> errcnt_reg == 32'h0)
    else $error("hold-off count not cleared");
  AST_ERR_CNT: assert property (holdoff && !err_clr |=> errcnt_reg == $past(errcnt_reg) + 32'h1
                                && errjob_reg == $past(acq_reg))
    else $error("hold-off error not counted");
  AST_OVF: assert property (res_seen ##0 !dio_ready_in |=> ovf_reg == $past(ovf_reg) + 32'h1)
    else $error("dio overflow not counted");
  AST_FIXED_INV: assert property (res_seen ##0 esrc[0][5] |=> !link_valid_out[0])
    else $error("fixed link bit marked valid");
  AST_PACK_RO: assert property (pack_reg && wr_pend_reg |=> $stable(bsrc_reg[0]))
    else $error("source changed in packed mode");
  AST_CYCLE: assert property (trig_taken ##1 res_seen |=> st_reg == LOG_IDLE)
    else $error("logger did not return to idle");
endmodule : qudit_readout_result_logger
